// ---- core/ppc_ctrl_regs.sv ----
// control register bank for the ppg/proximity engine
`default_nettype none
module ppc_ctrl_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire ppc_pkg::ppc_bus_s bus,
  output logic [7:0] rdata,
  input wire logic ledFlip,
  input wire logic proxIrq,
  input wire logic measDone,
  input wire logic statusRead,
  output ppc_pkg::ppc_ctl_s ctl
);
  import ppc_pkg::*;
  typedef struct packed {
    logic sleep;
    logic [1:0] mode;
    logic enable;
    logic [7:0] currLow;
    logic [1:0] currHigh;
    logic [7:0] rdata;
  } ppc_reg_s;
  ppc_reg_s st, next_st;
  logic autoClear;
  logic redSelect;
  logic fifoSlot;
  logic [7:0] modeByte;

  ppc_sleep_ctl u_sleep (
    .clk(clk),
    .rst_n(rst_n),
    .sleepEn(st.sleep),
    .engineEnable(st.enable),
    .proxIrq(proxIrq),
    .measDone(measDone),
    .statusRead(statusRead),
    .autoClear(autoClear)
  );

  ppc_led_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .engineEnable(st.enable),
    .measureMode(st.mode),
    .ledFlip(ledFlip),
    .sampleDone(measDone),
    .redSelect(redSelect),
    .fifoSlot(fifoSlot)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    modeByte = {4'h0, st.sleep, st.mode, st.enable};
    next_st = st;
    if (autoClear) next_st.enable = 1'b0;
    if (bus.wrStb) begin
      // upper bits are dropped; host keeps them zero
      case (bus.addr)
        ADDR_MODE_CTRL: begin
          next_st.enable = bus.wdata[BIT_ENABLE];
          next_st.mode = bus.wdata[BIT_MODE_LO +: 2];
          next_st.sleep = bus.wdata[BIT_SLEEP];
        end
        ADDR_CURR_LOW: next_st.currLow = bus.wdata;
        ADDR_CURR_HIGH: next_st.currHigh = bus.wdata[1:0];
        default: next_st.currLow = st.currLow;
      endcase
    end
    if (bus.rdStb) begin
      case (bus.addr)
        ADDR_MODE_CTRL: next_st.rdata = modeByte;
        ADDR_CURR_LOW: next_st.rdata = st.currLow;
        ADDR_CURR_HIGH: next_st.rdata = {6'h00, st.currHigh};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st.sleep <= RST_MODE_CTRL[BIT_SLEEP];
      st.mode <= RST_MODE_CTRL[BIT_MODE_LO +: 2];
      st.enable <= RST_MODE_CTRL[BIT_ENABLE];
      st.currLow <= RST_CURR_LOW;
      st.currHigh <= RST_CURR_HIGH;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata = st.rdata;
    ctl.engineEnable = st.enable;
    ctl.measureMode = st.mode;
    ctl.sleepAfterProxIrq = st.sleep;
    ctl.redSelect = redSelect;
    ctl.emitterCurrentCode = {st.currHigh, st.currLow};
    ctl.emitterOn = st.enable && ({st.currHigh, st.currLow} != CODE_OFF);
    ctl.fifoSlot = fifoSlot;
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_RESET_VALUES: assert property (@(posedge clk)
    !rst_n |=> ctl.emitterCurrentCode == 10'h1FF && !ctl.engineEnable)
    else $error("reset values wrong");
  AST_CODE_ASSEMBLY: assert property (@(posedge clk) disable iff (!rst_n)
    ctl.emitterCurrentCode == {st.currHigh, st.currLow})
    else $error("current code assembly wrong");
  AST_LOW_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wrStb && bus.addr == ADDR_CURR_LOW |=> ctl.emitterCurrentCode[7:0] == $past(bus.wdata))
    else $error("low byte write lost");
  AST_HIGH_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wrStb && bus.addr == ADDR_CURR_HIGH
    |=> ctl.emitterCurrentCode[9:8] == $past(bus.wdata[1:0]))
    else $error("high bits write lost");
  AST_OFF_CODE: assert property (@(posedge clk) disable iff (!rst_n)
    ctl.emitterCurrentCode == CODE_OFF |-> !ctl.emitterOn)
    else $error("emitter on at code zero");
  AST_NO_SLEEP: assert property (@(posedge clk) disable iff (!rst_n)
    ctl.engineEnable && !ctl.sleepAfterProxIrq && !bus.wrStb |=> ctl.engineEnable)
    else $error("engine stopped without sleep");
  AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wrStb && bus.addr == ADDR_MODE_CTRL |=> ctl.engineEnable == $past(bus.wdata[0]))
    else $error("enable write lost");
  AST_AUTO_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    autoClear && !bus.wrStb |=> !ctl.engineEnable ##0 ctl.measureMode == $past(st.mode))
    else $error("auto clear wrong");
  AST_READBACK: assert property (@(posedge clk) disable iff (!rst_n)
    bus.rdStb && bus.addr == ADDR_MODE_CTRL |=> rdata == $past(modeByte))
    else $error("mode readback wrong");
  AST_DUAL_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    ctl.measureMode == MODE_DUAL |-> ctl.redSelect == (fifoSlot ^ ledFlip))
    else $error("dual emitter order wrong");

  AST_PROX_IR: assert property (@(posedge clk) disable iff (!rst_n)
    ctl.measureMode == MODE_PROX |-> !ctl.redSelect)
    else $error("prox mode selected red");
  AST_EN_OFF_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !ctl.engineEnable && !bus.wrStb |=> !ctl.engineEnable)
    else $error("engine enabled without write");

  COV_AUTO_CLEAR: cover property (@(posedge clk) disable iff (!rst_n) autoClear);
  COV_RESERVED: cover property (@(posedge clk) disable iff (!rst_n)
    ctl.measureMode == 2'h3);
  COV_DUAL: cover property (@(posedge clk) disable iff (!rst_n)
    ctl.measureMode == MODE_DUAL && measDone);
  COV_SINGLE_RED: cover property (@(posedge clk) disable iff (!rst_n)
    ctl.measureMode == MODE_SINGLE && ctl.redSelect);
endmodule
`default_nettype wire

// ---- core/ppc_led_seq.sv ----
// emitter sequencer: picks the emitter per sample and the fifo slot in dual mode
`default_nettype none
module ppc_led_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic engineEnable,
  input wire logic [1:0] measureMode,
  input wire logic ledFlip,
  input wire logic sampleDone,
  output logic redSelect,
  output logic fifoSlot
);
  import ppc_pkg::*;
  typedef struct packed {
    logic phase;
  } ppc_seq_s;
  ppc_seq_s st, next_st;

  always_comb begin
    next_st = st;
    if (!engineEnable || measureMode != MODE_DUAL) next_st.phase = 1'b0;
    else if (sampleDone) next_st.phase = ~st.phase;
    case (measureMode)
      MODE_SINGLE: redSelect = ledFlip;
      MODE_DUAL: redSelect = st.phase ^ ledFlip;
      default: redSelect = 1'b0;
    endcase
    fifoSlot = st.phase;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end

  AST_PHASE_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
    engineEnable && measureMode == MODE_DUAL && sampleDone |=> fifoSlot != $past(fifoSlot))
    else $error("dual slot did not alternate");
  AST_SINGLE_FLIP: assert property (@(posedge clk) disable iff (!rst_n)
    measureMode == MODE_SINGLE |-> redSelect == ledFlip)
    else $error("single emitter choice wrong");
endmodule
`default_nettype wire

// ---- core/ppc_pkg.sv ----
// package: register map, field layout and carrier types for the ppg/prox control bank
`default_nettype none
package ppc_pkg;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h16;
  localparam logic [7:0] ADDR_CURR_LOW = 8'h17;
  localparam logic [7:0] ADDR_CURR_HIGH = 8'h18;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] RST_CURR_LOW = 8'hFF;
  localparam logic [1:0] RST_CURR_HIGH = 2'h1;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_MODE_LO = 1;
  localparam int BIT_SLEEP = 3;
  localparam logic [1:0] MODE_PROX = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_DUAL = 2'h2;
  localparam logic [9:0] CODE_OFF = 10'h000;

  typedef struct packed {
    logic wrStb;
    logic rdStb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ppc_bus_s;

  typedef struct packed {
    logic engineEnable;
    logic [1:0] measureMode;
    logic sleepAfterProxIrq;
    logic redSelect;
    logic [9:0] emitterCurrentCode;
    logic emitterOn;
    logic fifoSlot;
  } ppc_ctl_s;
endpackage
`default_nettype wire

// ---- core/ppc_sleep_ctl.sv ----
// auto-standby tracker: arms on a proximity interrupt, fires after done and status read
`default_nettype none
module ppc_sleep_ctl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleepEn,
  input wire logic engineEnable,
  input wire logic proxIrq,
  input wire logic measDone,
  input wire logic statusRead,
  output logic autoClear
);
  import ppc_pkg::*;
  typedef struct packed {
    logic irqSeen;
    logic doneSeen;
    logic readSeen;
  } ppc_slp_s;
  ppc_slp_s st, next_st;

  always_comb begin
    next_st = st;
    autoClear = 1'b0;
    if (!sleepEn || !engineEnable) begin
      next_st = '0;
    end else begin
      if (proxIrq) next_st.irqSeen = 1'b1;
      if (measDone && (st.irqSeen || proxIrq)) next_st.doneSeen = 1'b1;
      if (statusRead && (st.irqSeen || proxIrq)) next_st.readSeen = 1'b1;
      if (next_st.irqSeen && next_st.doneSeen && next_st.readSeen) begin
        autoClear = 1'b1;
        next_st = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end
endmodule
`default_nettype wire

// ---- sim/ppc_host_model.sv ----
// host master model driving the control bank strobe bus
`default_nettype none
module ppc_host_model
  import ppc_pkg::*;
(
  input wire logic clk,
  output var ppc_pkg::ppc_bus_s bus,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] keep;
  initial bus = '0;
  // unused upper bits always written as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    keep = (a == ADDR_MODE_CTRL) ? 8'h0F : (a == ADDR_CURR_HIGH) ? 8'h03 : 8'hFF;
    @(negedge clk);
    bus = '{1'b1, 1'b0, a, d & keep};
    @(negedge clk);
    bus = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    bus = '{1'b0, 1'b1, a, ~bus.wdata};
    @(negedge clk);
    d = rdata;
    bus = '{1'b0, 1'b0, ~a, ~bus.wdata};
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_ppg_prox_control_regs.sv ----
// self-checking bench for the ppg/prox control register bank
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_ppg_prox_control_regs
  import ppc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ledFlip = 1'b0;
  logic [2:0] evt = 3'h0;
  logic [7:0] rdata;
  logic [7:0] r;
  ppc_bus_s bus;
  ppc_ctl_s ctl;
  int failures = 0;
  int num_checks = 0;
  logic [9:0] codes [4] = '{10'h000, 10'h001, 10'h002, 10'h3FF};

  always #12.5 clk = ~clk;

  ppc_ctrl_regs i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .ledFlip(ledFlip),
    .proxIrq(evt[2]), .measDone(evt[1]), .statusRead(evt[0]), .ctl(ctl));
  ppc_host_model i_host (.clk(clk), .bus(bus), .rdata(rdata));

  //////////////////////////////////////////////////////////////////////////////
  task automatic pulse(input logic [2:0] v);
    @(negedge clk);
    evt = v;
    @(negedge clk);
    evt = 3'h0;
  endtask
  task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, r);
    `CHK(r, e)
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    failures++;
    complete_run();
  end

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    chkrd(ADDR_MODE_CTRL, 8'h00);
    chkrd(ADDR_CURR_LOW, 8'hFF);
    chkrd(ADDR_CURR_HIGH, 8'h01);
    `CHK(ctl.emitterCurrentCode, 10'h1FF)
    chkrd(8'h19, 8'h00);
    i_host.wr(ADDR_MODE_CTRL, 8'h01);
    foreach (codes[i]) begin
      i_host.wr(ADDR_CURR_LOW, codes[i][7:0]);
      i_host.wr(ADDR_CURR_HIGH, {6'h00, codes[i][9:8]});
      `CHK(ctl.emitterCurrentCode, codes[i])
      `CHK(ctl.emitterOn, codes[i] != CODE_OFF)
      chkrd(ADDR_CURR_HIGH, {6'h00, codes[i][9:8]});
    end
    for (int f = 0; f < 2; f++) begin
      ledFlip = f[0];
      i_host.wr(ADDR_MODE_CTRL, 8'h03);
      `CHK(ctl.measureMode, MODE_SINGLE)
      `CHK(ctl.redSelect, f[0])
      i_host.wr(ADDR_MODE_CTRL, 8'h05);
      `CHK(ctl.measureMode, MODE_DUAL)
      `CHK(ctl.redSelect, f[0])
      pulse(3'b010);
      `CHK(ctl.fifoSlot, 1'b1)
      `CHK(ctl.redSelect, ~f[0])
      pulse(3'b010);
      `CHK(ctl.fifoSlot, 1'b0)
    end
    ledFlip = 1'b0;
    i_host.wr(ADDR_MODE_CTRL, 8'h01);
    chkrd(ADDR_MODE_CTRL, 8'h01);
    pulse(3'b111);
    repeat (2) @(negedge clk);
    `CHK(ctl.engineEnable, 1'b1)
    i_host.wr(ADDR_MODE_CTRL, 8'h0D);
    pulse(3'b111);
    @(negedge clk);
    `CHK(ctl.engineEnable, 1'b0)
    chkrd(ADDR_MODE_CTRL, 8'h0C);
    `CHK(ctl.sleepAfterProxIrq, 1'b1)
    i_host.wr(ADDR_MODE_CTRL, 8'h09);
    pulse(3'b011);
    pulse(3'b100);
    `CHK(ctl.engineEnable, 1'b1)
    pulse(3'b010);
    pulse(3'b001);
    @(negedge clk);
    `CHK(ctl.engineEnable, 1'b0)
    i_host.wr(ADDR_MODE_CTRL, 8'h07);
    `CHK(ctl.measureMode, 2'h3)
    `CHK(ctl.redSelect, 1'b0)
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chkrd(ADDR_MODE_CTRL, 8'h00);
    `CHK(ctl.emitterCurrentCode, 10'h1FF)
    complete_run();
  end
endmodule
`default_nettype wire
